/* File: array_model.sv */
// Purpose: Array stand-in answering byte requests of the read path
// Assumes: One request outstanding
// Notes:   Slow mode answers a cycle later
`timescale 1ns/1ps
module array_model
(
   // Clock and request
   input  wire        clk_in,
   input  wire        slow_in,
   input  wire        req_in,
   input  wire [25:0] addr_in,
   // Answer
   output reg  [7:0]  data_out,
   output reg         valid_out
);
   reg req_q;
   wire hit = slow_in ? req_q : req_in;
   initial
   begin
      req_q = 1'b0;
      valid_out = 1'b0;
      data_out = 8'h00;
   end
   always @(posedge clk_in)
   begin
      req_q <= req_in;
      valid_out <= hit;
      data_out <= hit ? addr_in[7:0] ^ addr_in[15:8] ^ {6'h00, addr_in[25:24]} : ~data_out;
   end
endmodule

/* File: read_byte_fifo.v */
// Purpose: Byte FIFO between the array fetch and the output shifter
// Assumes: Depth is a power of two; clear empties it at once
// Notes:   in_ready_out is registered
`timescale 1ns/1ps
`include "serial_flash_read_path_defines.vh"

module read_byte_fifo
#(
   parameter WIDTH      = `BYTE_WIDTH,
   parameter DEPTH_LOG2 = `FIFO_DEPTH_LOG2
)
(
   // Clock and reset
   input  wire             clk_in,
   input  wire             reset_in,
   input  wire             clear_in,
   // Fill side
   input  wire             in_valid_in,
   output reg              in_ready_out,
   input  wire [WIDTH-1:0] in_data_in,
   // Drain side
   output wire             out_valid_out,
   input  wire             out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);

   localparam DEPTH = 1 << DEPTH_LOG2;

   reg  [WIDTH-1:0]      mem_q [0:DEPTH-1];
   reg  [DEPTH_LOG2:0]   wr_ptr_q;
   reg  [DEPTH_LOG2:0]   rd_ptr_q;
   wire [DEPTH_LOG2:0]   count;
   wire                  push;
   wire                  pop;
   wire [DEPTH_LOG2:0]   count_d;

   assign count         = wr_ptr_q - rd_ptr_q;
   assign out_valid_out = (count != {(DEPTH_LOG2+1){1'b0}});
   assign out_data_out  = mem_q[rd_ptr_q[DEPTH_LOG2-1:0]];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_ready_in & out_valid_out;
   assign count_d       = count + {{DEPTH_LOG2{1'b0}}, push} - {{DEPTH_LOG2{1'b0}}, pop};

   always @(posedge clk_in)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q[DEPTH_LOG2-1:0]] <= in_data_in;
      end
   end

   always @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         wr_ptr_q     <= {(DEPTH_LOG2+1){1'b0}};
         rd_ptr_q     <= {(DEPTH_LOG2+1){1'b0}};
         in_ready_out <= 1'b0;
      end
      else if (clear_in)
      begin
         wr_ptr_q     <= {(DEPTH_LOG2+1){1'b0}};
         rd_ptr_q     <= {(DEPTH_LOG2+1){1'b0}};
         in_ready_out <= 1'b1;
      end
      else
      begin
         wr_ptr_q     <= wr_ptr_q + {{DEPTH_LOG2{1'b0}}, push};
         rd_ptr_q     <= rd_ptr_q + {{DEPTH_LOG2{1'b0}}, pop};
         // Full is known one cycle ahead so ready never lies
         in_ready_out <= ~count_d[DEPTH_LOG2];
      end
   end

endmodule

/* File: serial_flash_read_path.v */
// Purpose: Read command path and address width handling of a serial flash
// Assumes: Link pins are oversampled by core_clk_in, at least 8x the serial clock
// Notes:   Array bytes come over a request/valid port into a FIFO
//
// Overview of operation
// - Exit opcode returns to 24-bit addressing
// - Width opcodes are eight bits, nothing more
// - Read 03h takes opcode and address rising
// - Data leaves MSB first on falling edges
// - Address advances per byte until deselect
// - Address wraps to zero past the top
// - Reads ignored while busy
// - Wide mode reads collect 32 address bits
// - Opcode 13h always takes 32 bits
// - Fast read: address rising, data falling
// - Quad mode fast read dummy from P[5:4]
// - Double edge read, six dummy clocks
// - 0Ch wide fast read only single-lane
// - Dual output: eight dummies, two lanes out
// - 3Ch accepted only in single-lane mode
// - Dual IO moves address and data two-wide
// - Dual IO dummy count from select bit
// - Any start byte, no alignment
// - Narrow mode prepends extension bits
// - Enter opcode switches to 32-bit addressing
// - Training pattern on all lanes in dummies
`timescale 1ns/1ps
`include "serial_flash_read_path_defines.vh"

module serial_flash_read_path
#(
   parameter FIFO_DEPTH_LOG2 = `FIFO_DEPTH_LOG2
)
(
   // Clock and reset
   input  wire                        core_clk_in,
   input  wire                        reset_in,
   // Link pins
   input  wire                        sclk_in,
   input  wire                        cs_n_in,
   input  wire                        io_lane_0_in,
   output reg                         io_lane_0_out,
   output reg                         io_lane_0_oe_out,
   input  wire                        io_lane_1_in,
   output reg                         io_lane_1_out,
   output reg                         io_lane_1_oe_out,
   // Configuration and status
   input  wire                        busy_in,
   input  wire                        quad_command_mode_in,
   input  wire [1:0]                  read_param_in,
   input  wire                        dummy_count_select_in,
   input  wire [1:0]                  upper_address_extension_in,
   input  wire                        training_pattern_enable_in,
   output reg                         address_width_state_out,
   // Array read port
   output reg                         mem_req_out,
   output reg  [`ARRAY_ADDR_BITS-1:0] mem_addr_out,
   input  wire [`BYTE_WIDTH-1:0]      mem_data_in,
   input  wire                        mem_valid_in,
   output wire                        mem_ready_out
);

   localparam ST_IDLE  = 3'h0;
   localparam ST_OPC   = 3'h1;
   localparam ST_ADDR  = 3'h2;
   localparam ST_DUMMY = 3'h3;
   localparam ST_DATA  = 3'h4;
   localparam ST_WIDTH = 3'h5;
   localparam ST_SKIP  = 3'h6;

   // Decoded read: {valid, force32, dual_io, double_edge, dual_out, dummy[3:0]}
   function [8:0] read_decode;
      input [7:0] op;
      input       quad;
      input [1:0] p;
      input       dc;
      reg   [3:0] fast_dummy;
      begin
         case (p)
            2'h0:    fast_dummy = `DUMMY_QUAD_P0;
            2'h1:    fast_dummy = `DUMMY_QUAD_P1;
            2'h2:    fast_dummy = `DUMMY_QUAD_P2;
            default: fast_dummy = `DUMMY_QUAD_P3;
         endcase
         case (op)
            `OP_READ:             read_decode = {5'h10, `DUMMY_NONE};
            `OP_WIDE_ADDR_READ:   read_decode = {5'h18, `DUMMY_NONE};
            `OP_FAST_READ:        read_decode = {5'h10,
                                     quad ? fast_dummy : `DUMMY_FAST_SINGLE};
            // Quad 0Ch is burst wrap, not served here
            `OP_WIDE_FAST_READ:   read_decode = quad ? 9'h000
                                     : {5'h18, `DUMMY_FAST_SINGLE};
            `OP_DOUBLE_EDGE_READ: read_decode = {5'h12, `DUMMY_DOUBLE_EDGE};
            `OP_DUAL_OUTPUT_READ: read_decode = {5'h11, `DUMMY_DUAL_OUTPUT};
            `OP_WIDE_DUAL_OUT_READ: read_decode = quad ? 9'h000
                                     : {5'h19, `DUMMY_DUAL_OUTPUT};
            `OP_DUAL_IO_READ:     read_decode = {5'h15,
                                     dc ? `DUMMY_DUAL_IO_DC1 : `DUMMY_DUAL_IO_DC0};
            default:              read_decode = 9'h000;
         endcase
      end
   endfunction

   // Pin synchronisers; stage one feeds stage two only
   reg         sclk_s1_q;
   reg         sclk_s2_q;
   reg         sclk_s3_q;
   reg         cs_n_s1_q;
   reg         cs_n_s2_q;
   reg         io0_s1_q;
   reg         io0_s2_q;
   reg         io1_s1_q;
   reg         io1_s2_q;

   reg  [2:0]  state_q;
   reg  [5:0]  cnt_q;
   reg  [7:0]  opc_q;
   reg  [31:0] addr_q;
   reg  [5:0]  addr_bits_q;
   reg         dual_io_q;
   reg         double_edge_q;
   reg         dual_out_q;
   reg  [3:0]  dummy_q;
   reg  [7:0]  sh_q;
   reg  [3:0]  bcnt_q;
   reg         start_q;
   reg  [`ARRAY_ADDR_BITS-1:0] start_addr_q;

   reg         fetch_on_q;
   reg         pend_q;
   reg         drop_q;
   reg  [`ARRAY_ADDR_BITS-1:0] fetch_addr_q;

   wire        rise;
   wire        fall;
   wire        selected;
   wire [7:0]  opc_next;
   wire [8:0]  dec;
   wire [5:0]  addr_step;
   wire [31:0] addr_next;
   wire        addr_take;
   wire        data_edge;
   wire [7:0]  out_byte;
   wire [3:0]  out_step;
   wire        pop;
   wire        fifo_valid;
   wire [7:0]  fifo_data;
   wire        push;
   wire [2:0]  pat_idx;
   wire [`ARRAY_ADDR_BITS-1:0] mapped_addr;

   assign rise      = sclk_s2_q & ~sclk_s3_q;
   assign fall      = ~sclk_s2_q & sclk_s3_q;
   assign selected  = ~cs_n_s2_q;
   assign opc_next  = {opc_q[6:0], io0_s2_q};
   assign dec       = read_decode(opc_next, quad_command_mode_in, read_param_in,
                                  dummy_count_select_in);
   assign addr_step = dual_io_q ? 6'h02 : 6'h01;
   // Double edge: first a rise, then both edges
   assign addr_take = rise | (double_edge_q & fall & (cnt_q != 6'h00));
   assign addr_next = dual_io_q ? {addr_q[29:0], io1_s2_q, io0_s2_q}
                                : {addr_q[30:0], io0_s2_q};
   // Narrow addresses take the extension bits
   assign mapped_addr = (addr_bits_q == `ADDR_BITS_WIDE)
                      ? addr_next[`ARRAY_ADDR_BITS-1:0]
                      : {upper_address_extension_in,
                         addr_next[`NARROW_ADDR_TOP:0]};
   assign data_edge = fall | (double_edge_q & rise);
   assign out_step  = dual_out_q ? 4'h2 : 4'h1;
   assign out_byte  = (bcnt_q == 4'h0) ? fifo_data : sh_q;
   assign pop       = (state_q == ST_DATA) & selected & data_edge & (bcnt_q == 4'h0);
   assign pat_idx   = cnt_q[2:0] - 3'h1;
   assign push      = mem_valid_in & pend_q & ~drop_q & ~start_q;

   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         cs_n_s1_q <= 1'b1;
         cs_n_s2_q <= 1'b1;
         io0_s1_q  <= 1'b0;
         io0_s2_q  <= 1'b0;
         io1_s1_q  <= 1'b0;
         io1_s2_q  <= 1'b0;
      end
      else
      begin
         sclk_s1_q <= sclk_in;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         cs_n_s1_q <= cs_n_in;
         cs_n_s2_q <= cs_n_s1_q;
         io0_s1_q  <= io_lane_0_in;
         io0_s2_q  <= io0_s1_q;
         io1_s1_q  <= io_lane_1_in;
         io1_s2_q  <= io1_s1_q;
      end
   end

   // Command sequencer
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_q                 <= ST_IDLE;
         cnt_q                   <= 6'h00;
         opc_q                   <= 8'h00;
         addr_q                  <= 32'h0000_0000;
         addr_bits_q             <= `ADDR_BITS_NARROW;
         dual_io_q               <= 1'b0;
         double_edge_q           <= 1'b0;
         dual_out_q              <= 1'b0;
         dummy_q                 <= 4'h0;
         sh_q                    <= 8'h00;
         bcnt_q                  <= 4'h0;
         start_q                 <= 1'b0;
         start_addr_q            <= {`ARRAY_ADDR_BITS{1'b0}};
         address_width_state_out <= `ADDR_WIDTH_STATE_RESET;
         io_lane_0_out           <= 1'b0;
         io_lane_0_oe_out        <= 1'b0;
         io_lane_1_out           <= 1'b0;
         io_lane_1_oe_out        <= 1'b0;
      end
      else
      begin
         start_q <= 1'b0;
         if (!selected)
         begin
            // Deselect ends any read and drops partial commands
            state_q          <= ST_IDLE;
            io_lane_0_oe_out <= 1'b0;
            io_lane_1_oe_out <= 1'b0;
            if (state_q == ST_WIDTH)
            begin
               // Width change only after exactly eight opcode bits
               address_width_state_out <= (opc_q == `OP_ENTER_WIDE_ADDR);
            end
         end
         else
         begin
            case (state_q)
               ST_IDLE:
               begin
                  state_q <= ST_OPC;
                  cnt_q   <= 6'h00;
               end
               ST_OPC:
               begin
                  if (rise)
                  begin
                     opc_q <= opc_next;
                     cnt_q <= cnt_q + 6'h01;
                     if (cnt_q == 6'h07)
                     begin
                        cnt_q         <= 6'h00;
                        addr_q        <= 32'h0000_0000;
                        dual_io_q     <= dec[6];
                        double_edge_q <= dec[5];
                        dual_out_q    <= dec[4];
                        dummy_q       <= dec[3:0];
                        addr_bits_q   <= (dec[7] | address_width_state_out)
                                       ? `ADDR_BITS_WIDE : `ADDR_BITS_NARROW;
                        if ((opc_next == `OP_EXIT_WIDE_ADDR) ||
                            (opc_next == `OP_ENTER_WIDE_ADDR))
                        begin
                           state_q <= ST_WIDTH;
                        end
                        else if (dec[8] && !busy_in)
                        begin
                           state_q <= ST_ADDR;
                        end
                        else
                        begin
                           // Busy or not a read: leave running cycle alone
                           state_q <= ST_SKIP;
                        end
                     end
                  end
               end
               ST_ADDR:
               begin
                  if (addr_take)
                  begin
                     addr_q <= addr_next;
                     cnt_q  <= cnt_q + addr_step;
                     if (cnt_q + addr_step == addr_bits_q)
                     begin
                        // Any byte may start a read
                        start_q      <= 1'b1;
                        start_addr_q <= mapped_addr;
                        cnt_q        <= {2'b00, dummy_q};
                        bcnt_q       <= 4'h0;
                        state_q      <= (dummy_q == 4'h0) ? ST_DATA : ST_DUMMY;
                     end
                  end
               end
               ST_DUMMY:
               begin
                  if (fall)
                  begin
                     // Pattern on every lane, else lanes stay released
                     io_lane_0_out    <= training_pattern_enable_in
                                       & |((`TRAINING_PATTERN >> pat_idx) & 8'h01);
                     io_lane_1_out    <= training_pattern_enable_in
                                       & |((`TRAINING_PATTERN >> pat_idx) & 8'h01);
                     io_lane_0_oe_out <= training_pattern_enable_in;
                     io_lane_1_oe_out <= training_pattern_enable_in;
                  end
                  if (rise)
                  begin
                     cnt_q <= cnt_q - 6'h01;
                     if (cnt_q == 6'h01)
                     begin
                        state_q <= ST_DATA;
                     end
                  end
               end
               ST_DATA:
               begin
                  if (data_edge)
                  begin
                     io_lane_1_out    <= out_byte[7];
                     io_lane_1_oe_out <= 1'b1;
                     io_lane_0_out    <= out_byte[6];
                     io_lane_0_oe_out <= dual_out_q;
                     sh_q             <= dual_out_q ? {out_byte[5:0], 2'b00}
                                                    : {out_byte[6:0], 1'b0};
                     bcnt_q           <= ((bcnt_q == 4'h0) ? 4'h8 : bcnt_q) - out_step;
                  end
               end
               ST_WIDTH:
               begin
                  // Extra clocks void the width command
                  if (rise)
                  begin
                     state_q <= ST_SKIP;
                  end
               end
               ST_SKIP:
               begin
                  state_q <= ST_SKIP;
               end
               default:
               begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Array prefetch; one request in flight keeps the FIFO from overflowing
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         fetch_on_q   <= 1'b0;
         pend_q       <= 1'b0;
         drop_q       <= 1'b0;
         fetch_addr_q <= {`ARRAY_ADDR_BITS{1'b0}};
         mem_req_out  <= 1'b0;
         mem_addr_out <= {`ARRAY_ADDR_BITS{1'b0}};
      end
      else
      begin
         mem_req_out <= 1'b0;
         if (mem_valid_in && pend_q)
         begin
            pend_q <= 1'b0;
            drop_q <= 1'b0;
         end
         if (!selected)
         begin
            fetch_on_q <= 1'b0;
            drop_q     <= pend_q & ~mem_valid_in;
         end
         else if (start_q)
         begin
            // First byte asked at once, else it misses the first falling edge
            fetch_on_q   <= 1'b1;
            mem_req_out  <= 1'b1;
            mem_addr_out <= start_addr_q;
            pend_q       <= 1'b1;
            fetch_addr_q <= start_addr_q + {{(`ARRAY_ADDR_BITS-1){1'b0}}, 1'b1};
         end
         else if (fetch_on_q && !pend_q && !mem_req_out && mem_ready_out)
         begin
            mem_req_out  <= 1'b1;
            mem_addr_out <= fetch_addr_q;
            pend_q       <= 1'b1;
            // Overflow wraps to zero
            fetch_addr_q <= fetch_addr_q + {{(`ARRAY_ADDR_BITS-1){1'b0}}, 1'b1};
         end
      end
   end

   read_byte_fifo
   #(
      .WIDTH      (`BYTE_WIDTH),
      .DEPTH_LOG2 (FIFO_DEPTH_LOG2)
   )
   u_fifo
   (
      .clk_in        (core_clk_in),
      .reset_in      (reset_in),
      .clear_in      (start_q | ~selected),
      .in_valid_in   (push),
      .in_ready_out  (mem_ready_out),
      .in_data_in    (mem_data_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (pop),
      .out_data_out  (fifo_data)
   );

endmodule

/* File: serial_flash_read_path_defines.vh */
// Purpose: Opcodes, widths, counts and reset values of the read path
// Assumes: Included by the read path and its byte FIFO only
// Notes:   Definitions only; no logic lives here
`ifndef SERIAL_FLASH_READ_PATH_DEFINES_VH
`define SERIAL_FLASH_READ_PATH_DEFINES_VH

// Opcodes
`define OP_EXIT_WIDE_ADDR      8'he9
`define OP_ENTER_WIDE_ADDR     8'hb7
`define OP_READ                8'h03
`define OP_WIDE_ADDR_READ      8'h13
`define OP_FAST_READ           8'h0b
`define OP_WIDE_FAST_READ      8'h0c
`define OP_DOUBLE_EDGE_READ    8'h0d
`define OP_DUAL_OUTPUT_READ    8'h3b
`define OP_WIDE_DUAL_OUT_READ  8'h3c
`define OP_DUAL_IO_READ        8'hbb

// Address lengths in bits
`define ADDR_BITS_NARROW       6'h18
`define ADDR_BITS_WIDE         6'h20
`define NARROW_ADDR_TOP        23

// Array address width, 512Mb of bytes
`define ARRAY_ADDR_BITS        26

// Dummy clock counts
`define DUMMY_NONE             4'h0
`define DUMMY_FAST_SINGLE      4'h8
`define DUMMY_QUAD_P0          4'ha
`define DUMMY_QUAD_P1          4'h4
`define DUMMY_QUAD_P2          4'h6
`define DUMMY_QUAD_P3          4'h8
`define DUMMY_DOUBLE_EDGE      4'h6
`define DUMMY_DUAL_OUTPUT      4'h8
`define DUMMY_DUAL_IO_DC0      4'h4
`define DUMMY_DUAL_IO_DC1      4'h6

// Training pattern shifted out during dummy clocks
`define TRAINING_PATTERN       8'h34

// Reset value, FIFO depth and byte width
`define ADDR_WIDTH_STATE_RESET 1'b0
`define FIFO_DEPTH_LOG2        3
`define BYTE_WIDTH             8

`endif

/* File: serial_flash_read_path_monitor.sv */
// Purpose: Port checker for the read path
// Assumes: Sees only top level ports
// Notes:   Helper tracks stream address
`timescale 1ns/1ps
module serial_flash_read_path_monitor
(
   input wire        core_clk_in,
   input wire        reset_in,
   input wire        sclk_in,
   input wire        cs_n_in,
   input wire        io_lane_0_in,
   input wire        io_lane_0_out,
   input wire        io_lane_0_oe_out,
   input wire        io_lane_1_in,
   input wire        io_lane_1_out,
   input wire        io_lane_1_oe_out,
   input wire        busy_in,
   input wire        quad_command_mode_in,
   input wire [1:0]  read_param_in,
   input wire        dummy_count_select_in,
   input wire [1:0]  upper_address_extension_in,
   input wire        training_pattern_enable_in,
   input wire        address_width_state_out,
   input wire        mem_req_out,
   input wire [25:0] mem_addr_out,
   input wire [7:0]  mem_data_in,
   input wire        mem_valid_in,
   input wire        mem_ready_out
);
   reg        seen_q;
   reg [25:0] prev_q;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
         seen_q <= 1'b0;
      else if (mem_req_out)
         seen_q <= 1'b1;
      else if (cs_n_in)
         seen_q <= 1'b0;
   end
   always @(posedge core_clk_in)
   begin
      if (mem_req_out)
         prev_q <= mem_addr_out;
   end
   property p_req_pulse; mem_req_out |=> !mem_req_out; endproperty
   a_req_pulse: assert property (p_req_pulse)
      else $error("request pulse too long");
   property p_addr_hold; $changed(mem_addr_out) |-> mem_req_out; endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved without request");
   property p_req_room; mem_req_out |-> $past(mem_ready_out); endproperty
   a_req_room: assert property (p_req_room)
      else $error("request without buffer room");
   property p_valid_gap; mem_valid_in |-> !mem_req_out; endproperty
   a_valid_gap: assert property (p_valid_gap)
      else $error("request while answer pending");
   property p_addr_step; mem_req_out && seen_q |-> mem_addr_out == prev_q + 26'h1; endproperty
   a_addr_step: assert property (p_addr_step)
      else $error("stream address not sequential");
   property p_width_cs; $changed(address_width_state_out) |-> $past(cs_n_in, 2); endproperty
   a_width_cs: assert property (p_width_cs)
      else $error("width changed while selected");
   property p_oe_idle; cs_n_in [*8] |-> !io_lane_0_oe_out && !io_lane_1_oe_out; endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("lane driven while deselected");
   property p_oe_start; $rose(io_lane_1_oe_out) |-> !$past(cs_n_in, 3); endproperty
   a_oe_start: assert property (p_oe_start)
      else $error("lane driven without selection");
   c_stream: cover property (mem_req_out && seen_q);
   c_wide: cover property ($rose(address_width_state_out));
   c_dual: cover property ($rose(io_lane_0_oe_out));
endmodule
bind serial_flash_read_path serial_flash_read_path_monitor mon (.*);

/* File: serial_flash_read_path_tb.sv */
// Purpose: Self-checking bench for the read path
// Assumes: Serial clock of 80 ns, eight core cycles per bit
// Notes:   Data bits sampled just before the next fall
`timescale 1ns/1ps
module serial_flash_read_path_tb;
   reg         core_clk_in, reset_in, sclk, cs_n, d0, d1, busy, quad, dc, tpe, slow;
   reg  [1:0]  param, ext;
   reg  [7:0]  tp;
   wire        o0, e0, o1, e1, aws, req, ready, mval;
   wire [25:0] maddr;
   wire [7:0]  mdata;
   wire        w0 = e0 ? o0 : d0;
   wire        w1 = e1 ? o1 : d1;
   integer     fails, n_checks, p;
   serial_flash_read_path dut
   (
      .core_clk_in(core_clk_in), .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .io_lane_0_in(w0), .io_lane_0_out(o0), .io_lane_0_oe_out(e0), .io_lane_1_in(w1),
      .io_lane_1_out(o1), .io_lane_1_oe_out(e1), .busy_in(busy), .quad_command_mode_in(quad),
      .read_param_in(param), .dummy_count_select_in(dc), .upper_address_extension_in(ext),
      .training_pattern_enable_in(tpe), .address_width_state_out(aws), .mem_req_out(req),
      .mem_addr_out(maddr), .mem_data_in(mdata), .mem_valid_in(mval), .mem_ready_out(ready)
   );
   array_model mem (.clk_in(core_clk_in), .slow_in(slow), .req_in(req), .addr_in(maddr),
      .data_out(mdata), .valid_out(mval));
   initial
   begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   task tick(input integer n);
      repeat (n) @(posedge core_clk_in) #1;
   endtask
   task chk(input c, input [8*16-1:0] m);
      begin
         n_checks = n_checks + 1;
         if (c !== 1'b1)
         begin
            fails = fails + 1;
            $display("Error at %0t: %0s", $time, m);
         end
      end
   endtask
   task finish_test;
      begin
         $display("Checks %0d, errors %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task clk(input a0, input a1, output reg c0, output reg c1);
      begin
         d0 = a0;
         d1 = a1;
         tick(4);
         sclk = 1'b1;
         tick(4);
         c0 = w0;
         c1 = w1;
         sclk = 1'b0;
      end
   endtask
   task sbyte(input [7:0] b);
      reg x, y;
      integer i;
      for (i = 7; i >= 0; i = i - 1)
         clk(b[i], 1'b0, x, y);
   endtask
   task wcmd(input [7:0] op, input extra);
      reg x, y;
      begin
         cs_n = 1'b0;
         sbyte(op);
         if (extra)
            clk(1'b0, 1'b0, x, y);
         cs_n = 1'b1;
         tick(8);
      end
   endtask
   // md: 0 single lane, 1 dual data, 2 dual address and data
   task rd(input [7:0] op, input integer ab, input [31:0] a, input integer dm,
      input integer md, input integer nb, input ok);
      reg [7:0] got, v;
      reg [25:0] fa, ad;
      reg x, y;
      integer i, k;
      begin
         fa = (ab == 24) ? {ext, a[23:0]} : a[25:0];
         cs_n = 1'b0;
         sbyte(op);
         for (i = ab - 1; i >= 0; i = i - ((md == 2) ? 2 : 1))
            if (md == 2) clk(a[i-1], a[i], x, y); else clk(a[i], 1'b0, x, y);
         for (i = 0; i < dm; i = i + 1)
         begin
            clk(1'b0, 1'b0, x, y);
            tp = {tp[6:0], y};
         end
         for (k = 0; k < nb; k = k + 1)
         begin
            for (i = 0; i < 8; i = i + ((md != 0) ? 2 : 1))
            begin
               clk(~x, ~y, x, y);
               got = (md != 0) ? {got[5:0], y, x} : {got[6:0], y};
            end
            ad = fa + k;
            v = ad[7:0] ^ ad[15:8] ^ {6'h00, ad[25:24]};
            chk(ok ? got === v : {e0, e1} === 2'b00, "read data");
         end
         cs_n = 1'b1;
         tick(8);
      end
   endtask
   task t_width;
      begin
         ext = 2'b10;
         rd(8'h03, 24, 32'h0012_fffe, 0, 0, 2, 1'b1);
         wcmd(8'hb7, 1'b0);
         chk(aws === 1'b1, "enter wide");
         rd(8'h03, 32, 32'h03ff_fffe, 0, 0, 3, 1'b1);
         wcmd(8'he9, 1'b1);
         chk(aws === 1'b1, "exit with extra");
         wcmd(8'he9, 1'b0);
         chk(aws === 1'b0, "exit wide");
         rd(8'h13, 32, 32'h0123_4567, 0, 0, 2, 1'b1);
      end
   endtask
   task t_fast_dual;
      begin
         slow = 1'b1;
         rd(8'h0b, 24, 32'h0000_0001, 8, 0, 2, 1'b1);
         rd(8'h0c, 32, 32'h02ab_cdef, 8, 0, 2, 1'b1);
         rd(8'h3b, 24, 32'h0055_aa33, 8, 1, 2, 1'b1);
         rd(8'h3c, 32, 32'h0133_0102, 8, 1, 2, 1'b1);
         dc = 1'b0;
         rd(8'hbb, 24, 32'h0000_7f81, 4, 2, 2, 1'b1);
         dc = 1'b1;
         rd(8'hbb, 24, 32'h00c3_0005, 6, 2, 2, 1'b1);
         slow = 1'b0;
      end
   endtask
   task t_quad;
      begin
         quad = 1'b1;
         for (p = 0; p < 4; p = p + 1)
         begin
            param = p;
            rd(8'h0b, 24, 32'h0000_0100 + p, (p == 0) ? 10 : p * 2 + 2, 0, 1, 1'b1);
         end
         rd(8'h0c, 32, 32'h0000_0040, 8, 0, 1, 1'b0);
         rd(8'h3c, 32, 32'h0000_0040, 8, 1, 1, 1'b0);
         quad = 1'b0;
      end
   endtask
   task t_abort;
      begin
         busy = 1'b1;
         rd(8'h03, 24, 32'h0000_0010, 0, 0, 1, 1'b0);
         busy = 1'b0;
         cs_n = 1'b0;
         sbyte(8'h03);
         sbyte(8'h12);
         cs_n = 1'b1;
         tick(8);
         rd(8'h03, 24, 32'h0000_0020, 0, 0, 1, 1'b1);
         tpe = 1'b1;
         rd(8'h0b, 24, 32'h0000_0030, 8, 0, 1, 1'b1);
         chk(tp === 8'h34, "training bits");
         tpe = 1'b0;
      end
   endtask
   initial
   begin
      {reset_in, cs_n} = 2'b11;
      {sclk, d0, d1, busy, quad, dc, tpe, slow} = 8'h00;
      {param, ext, tp} = 12'h000;
      fails = 0;
      n_checks = 0;
      tick(20);
      reset_in = 1'b0;
      tick(4);
      chk(aws === 1'b0, "width reset");
      t_width;
      t_fast_dual;
      t_quad;
      t_abort;
      finish_test;
   end
   initial
   begin
      #900000;
      fails = fails + 1;
      finish_test;
   end
endmodule
